// >>> core/drps_pkg.sv
// package for the dram refresh / power state block
// assumes a 125 MHz system clock sampling the command pins
package drps_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // timing figures in ns (plain defaults), converted to cycles; the power-down exit figures are given in clocks
  localparam int T_RFC_NS = 128;
  localparam int T_CKE_NS = 8;
  localparam int T_XSNR_NS = 138;
  localparam int T_INTREF_NS = 7800;
  localparam int T_INTREF_HOT_NS = 3900;
  localparam int T_XP_CK = 2;
  localparam int T_XARD_CK = 2;
  localparam int T_XARDS_CK = 8;
  localparam int RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKE_CYC = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XSNR_CYC = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTREF_CYC = T_INTREF_NS / CLK_PERIOD_NS;
  localparam int INTREF_HOT_CYC = T_INTREF_HOT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int NUM_BANKS = 8;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int MR_LOWPWR_BIT = 12;
  localparam int EMR_HOT_BIT = 7;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_REFRESH = 6'b00_0010,
    ST_SELFREF = 6'b00_0100,
    ST_SR_EXIT = 6'b00_1000,
    ST_PWRDN = 6'b01_0000,
    ST_PD_EXIT = 6'b10_0000
  } drps_state_e;
endpackage

// >>> core/drps_timer.sv
// down counter used for every timed wait of the block
// assumes load and start values come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module drps_timer (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [drps_pkg::CNT_W-1:0] value_i,
  output logic done_o
);
  logic [drps_pkg::CNT_W-1:0] cnt_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// >>> core/drps_core.sv
// dram command-level refresh, self refresh and power-down state keeper
// assumes command pins are sampled on the rising ck edge, here sys_clk_i;
// pins arrive from outside and are synchronised first.
// Function
// - refresh decoded from cs ras cas low, we high; internal bank counter advances.
// - refresh leaves banks idle; nothing before tRFC elapses.
// - refresh with cke low enters self refresh, internally timed.
// - self refresh ignores inputs but cke; dll off on entry, on at exit.
// - one internal refresh within tCKE; residence at least tCKE.
// - cke low with nop or deselect enters power-down.
// - idle banks give precharge power-down, open row active; A12 picks exit.
// - power-down gates buffers, dll off in precharge power-down.
// - nop is cs low others high; deselect cs high; bursts continue.
`timescale 1ns/1ns
`default_nettype none
module drps_core (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic cke_i,
  input wire logic [drps_pkg::NUM_BANKS-1:0] bank_open_i,
  input wire logic burst_busy_i,
  input wire logic mr_lowpwr_exit_i,
  input wire logic emr_hot_i,
  input wire logic dll_reset_i,
  output logic refresh_o,
  output logic [2:0] ref_bank_o,
  output logic self_refresh_o,
  output logic power_down_o,
  output logic active_pd_o,
  output logic dll_enable_o,
  output logic buffers_off_o,
  output logic cmd_ready_o,
  output logic content_lost_o,
  output logic timing_err_o
);
  // ===========================================================
  // input synchronisers
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 5'h1f;
      pin_s2_q <= 5'h1f;
    end else begin
      pin_s1_q <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire cke = pin_s2_q[4];
  wire [3:0] cmd = pin_s2_q[3:0];
  // ===========================================================
  // command decode
  wire is_ref = (cmd == drps_pkg::CMD_REF);
  wire is_nop = (cmd == drps_pkg::CMD_NOP) || cmd[3];
  wire all_idle = (bank_open_i == '0);
  // ===========================================================
  // state machine
  drps_pkg::drps_state_e state_q;
  drps_pkg::drps_state_e state_d;
  logic cke_prev_q;
  logic tload;
  logic [drps_pkg::CNT_W-1:0] tval;
  logic tdone;
  logic iref_load;
  logic iref_done;
  logic active_pd_q;
  logic content_lost_q;
  logic timing_err_q;
  logic [2:0] ref_bank_q;
  logic refresh_q;
  drps_timer u_wait (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(tload),
    .value_i(tval),
    .done_o(tdone)
  );
  // internal refresh interval; doubled rate when hot
  wire [drps_pkg::CNT_W-1:0] iref_val = emr_hot_i ?
    drps_pkg::CNT_W'(drps_pkg::INTREF_HOT_CYC) : drps_pkg::CNT_W'(drps_pkg::INTREF_CYC);
  drps_timer u_iref (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(iref_load),
    .value_i(iref_val),
    .done_o(iref_done)
  );
  wire in_sr = (state_q == drps_pkg::ST_SELFREF);
  wire sr_enter = (state_q == drps_pkg::ST_IDLE) && is_ref && !cke && cke_prev_q;
  wire ext_ref = (state_q == drps_pkg::ST_IDLE) && is_ref && cke && all_idle;
  // first internal refresh fires right at entry, well inside tCKE
  wire int_ref = sr_enter || (in_sr && iref_done);
  assign iref_load = int_ref;
  wire pd_enter = (state_q == drps_pkg::ST_IDLE) && is_nop && !cke && cke_prev_q
    && !burst_busy_i;
  wire sr_exit = in_sr && cke && tdone;
  wire pd_exit = (state_q == drps_pkg::ST_PWRDN) && cke && is_nop;
  // cke drop while a command could be live, not a recognised entry
  wire async_drop = (state_q == drps_pkg::ST_IDLE) && !cke && cke_prev_q
    && !is_ref && !is_nop;
  wire [drps_pkg::CNT_W-1:0] exit_slow = drps_pkg::CNT_W'(drps_pkg::T_XARDS_CK);
  wire [drps_pkg::CNT_W-1:0] exit_fast = drps_pkg::CNT_W'(drps_pkg::T_XARD_CK);
  wire [drps_pkg::CNT_W-1:0] exit_pre = drps_pkg::CNT_W'(drps_pkg::T_XP_CK);
  wire [drps_pkg::CNT_W-1:0] exit_cyc = active_pd_q ? (mr_lowpwr_exit_i ? exit_slow : exit_fast)
    : exit_pre;
  always_comb begin
    state_d = state_q;
    tload = 1'b0;
    tval = '0;
    unique case (state_q)
      drps_pkg::ST_IDLE: begin
        if (sr_enter) begin
          state_d = drps_pkg::ST_SELFREF;
          tload = 1'b1;
          tval = drps_pkg::CNT_W'(drps_pkg::CKE_CYC);
        end else if (ext_ref) begin
          state_d = drps_pkg::ST_REFRESH;
          tload = 1'b1;
          tval = drps_pkg::CNT_W'(drps_pkg::RFC_CYC);
        end else if (pd_enter) begin
          state_d = drps_pkg::ST_PWRDN;
        end
      end
      drps_pkg::ST_REFRESH: begin
        if (tdone) begin
          state_d = drps_pkg::ST_IDLE;
        end
      end
      drps_pkg::ST_SELFREF: begin
        if (sr_exit) begin
          state_d = drps_pkg::ST_SR_EXIT;
          tload = 1'b1;
          tval = drps_pkg::CNT_W'(drps_pkg::XSNR_CYC);
        end
      end
      drps_pkg::ST_SR_EXIT: begin
        if (tdone) begin
          state_d = drps_pkg::ST_IDLE;
        end
      end
      drps_pkg::ST_PWRDN: begin
        if (pd_exit) begin
          state_d = drps_pkg::ST_PD_EXIT;
          tload = 1'b1;
          tval = exit_cyc;
        end
      end
      drps_pkg::ST_PD_EXIT: begin
        if (tdone) begin
          state_d = drps_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = drps_pkg::ST_IDLE;
      end
    endcase
  end
  // ===========================================================
  // registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= drps_pkg::ST_IDLE;
      cke_prev_q <= 1'b0;
      active_pd_q <= 1'b0;
      ref_bank_q <= 3'h0;
      refresh_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_prev_q <= cke;
      refresh_q <= ext_ref || int_ref;
      if (pd_enter) begin
        active_pd_q <= !all_idle;
      end
      if (ext_ref || int_ref) begin
        ref_bank_q <= ref_bank_q + 3'h1;
      end
    end
  end
  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      content_lost_q <= 1'b0;
      timing_err_q <= 1'b0;
    end else begin
      if (async_drop) begin
        content_lost_q <= 1'b1;
      end else if (dll_reset_i) begin
        content_lost_q <= 1'b0;
      end
      // any non-nop command during a timed wait is a controller fault
      if (!is_nop && (state_q == drps_pkg::ST_REFRESH || state_q == drps_pkg::ST_SR_EXIT
          || state_q == drps_pkg::ST_PD_EXIT)) begin
        timing_err_q <= 1'b1;
      end else if (dll_reset_i) begin
        timing_err_q <= 1'b0;
      end
    end
  end
  // ===========================================================
  // registered outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      self_refresh_o <= 1'b0;
      power_down_o <= 1'b0;
      active_pd_o <= 1'b0;
      dll_enable_o <= 1'b1;
      buffers_off_o <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else begin
      self_refresh_o <= (state_d == drps_pkg::ST_SELFREF);
      power_down_o <= (state_d == drps_pkg::ST_PWRDN);
      active_pd_o <= (state_d == drps_pkg::ST_PWRDN) && (pd_enter ? !all_idle : active_pd_q);
      // dll off in self refresh and precharge power-down only
      dll_enable_o <= !((state_d == drps_pkg::ST_SELFREF) || ((state_d == drps_pkg::ST_PWRDN)
        && !(pd_enter ? !all_idle : active_pd_q)));
      buffers_off_o <= (state_d == drps_pkg::ST_SELFREF) || (state_d == drps_pkg::ST_PWRDN);
      cmd_ready_o <= (state_d == drps_pkg::ST_IDLE);
    end
  end
  assign refresh_o = refresh_q;
  assign ref_bank_o = ref_bank_q;
  assign content_lost_o = content_lost_q;
  assign timing_err_o = timing_err_q;
endmodule
`default_nettype wire

// >>> tb/drps_core_chk.sv
// port assertions for the refresh / power state block
// assumes it is bound into every drps_core instance
`timescale 1ns/1ns
`default_nettype none
module drps_core_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic cke_i,
  input wire logic [drps_pkg::NUM_BANKS-1:0] bank_open_i,
  input wire logic burst_busy_i,
  input wire logic dll_reset_i,
  input wire logic mr_lowpwr_exit_i,
  input wire logic refresh_o,
  input wire logic self_refresh_o,
  input wire logic power_down_o,
  input wire logic active_pd_o,
  input wire logic dll_enable_o,
  input wire logic buffers_off_o,
  input wire logic cmd_ready_o,
  input wire logic content_lost_o
);
  // ====
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_pulse; refresh_o |=> !refresh_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long refresh");
  property p_rfc;
    refresh_o && !self_refresh_o |-> !cmd_ready_o ##16 !cmd_ready_o ##1 cmd_ready_o;
  endproperty
  a_rfc: assert property (p_rfc) else $error("bad tRFC wait");
  property p_sr_in; $rose(self_refresh_o) |-> refresh_o && !dll_enable_o; endproperty
  a_sr_in: assert property (p_sr_in) else $error("bad sr entry");
  property p_sr_ign; self_refresh_o && !cke_i |=> self_refresh_o && !dll_enable_o; endproperty
  a_sr_ign: assert property (p_sr_ign) else $error("sr left early");
  property p_pd; power_down_o |-> buffers_off_o && (active_pd_o || !dll_enable_o); endproperty
  a_pd: assert property (p_pd) else $error("pd state");
  property p_apd; power_down_o |-> active_pd_o == (|bank_open_i); endproperty
  a_apd: assert property (p_apd) else $error("pd kind");
  property p_busy; $rose(power_down_o) |-> !$past(burst_busy_i); endproperty
  a_busy: assert property (p_busy) else $error("pd in burst");
  property p_lost; content_lost_o && !dll_reset_i |=> content_lost_o; endproperty
  a_lost: assert property (p_lost) else $error("lost flag dropped");
  // exit wait counted from the first cycle out of power-down
  property p_xslow;
    $fell(power_down_o) && $past(active_pd_o) && $past(mr_lowpwr_exit_i)
      |-> !cmd_ready_o ##8 !cmd_ready_o ##1 cmd_ready_o;
  endproperty
  a_xslow: assert property (p_xslow) else $error("slow pd exit wait");
  property p_xfast;
    $fell(power_down_o) && !($past(active_pd_o) && $past(mr_lowpwr_exit_i))
      |-> !cmd_ready_o ##2 !cmd_ready_o ##1 cmd_ready_o;
  endproperty
  a_xfast: assert property (p_xfast) else $error("fast pd exit wait");
endmodule
bind drps_core drps_core_chk u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .cke_i(cke_i), .bank_open_i(bank_open_i), .burst_busy_i(burst_busy_i),
  .dll_reset_i(dll_reset_i), .mr_lowpwr_exit_i(mr_lowpwr_exit_i),
  .refresh_o(refresh_o), .self_refresh_o(self_refresh_o),
  .power_down_o(power_down_o), .active_pd_o(active_pd_o), .dll_enable_o(dll_enable_o),
  .buffers_off_o(buffers_off_o), .cmd_ready_o(cmd_ready_o), .content_lost_o(content_lost_o));
`default_nettype wire

// >>> tb/drps_ctrl_model.sv
// controller model driving command pins and clock enable
// assumes the bench calls send from one process
`timescale 1ns/1ns
`default_nettype none
module drps_ctrl_model (
  input wire logic sys_clk_i,
  output logic [3:0] cmd_o,
  output logic cke_o
);
  initial begin
    cmd_o = drps_pkg::CMD_NOP;
    cke_o = 1'b1;
  end
  // idle cycles mix nop and deselect; deselect carries junk on the other lines
  // no read is ever issued, so read-to-precharge spacing never comes into play
  task automatic send(input logic [3:0] c, input logic k, input int gap);
    @(negedge sys_clk_i);
    cmd_o = c;
    cke_o = k;
    repeat (gap + 1) begin
      @(negedge sys_clk_i);
      cmd_o = $urandom % 2 ? drps_pkg::CMD_NOP : {1'b1, 3'($urandom)};
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for drps_core against an integer model
// assumes the controller model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] cmd;
  logic cke;
  logic [7:0] banks = 8'h00;
  logic busy = 1'b0;
  logic slow = 1'b0;
  logic hot = 1'b0;
  logic dllr = 1'b0;
  logic rf, sr, pd, apd, dll, boff, rdy, lost, terr;
  logic [2:0] bank;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nref = 0;
  int seen = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  drps_ctrl_model ctl (.sys_clk_i(sys_clk_i), .cmd_o(cmd), .cke_o(cke));
  drps_core dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cmd[3]),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .cke_i(cke), .bank_open_i(banks),
    .burst_busy_i(busy), .mr_lowpwr_exit_i(slow), .emr_hot_i(hot), .dll_reset_i(dllr),
    .refresh_o(rf), .ref_bank_o(bank), .self_refresh_o(sr), .power_down_o(pd),
    .active_pd_o(apd), .dll_enable_o(dll), .buffers_off_o(boff), .cmd_ready_o(rdy),
    .content_lost_o(lost), .timing_err_o(terr));
  // ====
  // checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (rf === 1'b1) seen <= seen + 1;
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end
  // ====
  // scenarios
  initial begin
    void'($urandom(83));
    hot = 1'($urandom);
    repeat (12) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    chk({rdy, dll, sr, pd}, 8'h0c);
    repeat (6) begin
      // spacing stays far inside the posting limit
      ctl.send(drps_pkg::CMD_REF, 1'b1, 17 + $urandom % 4);
      nref++;
    end
    chk(8'(seen), 8'(nref));
    chk(bank, 8'(nref % 8));
    banks = 8'h01 << ($urandom % 8);
    ctl.send(drps_pkg::CMD_REF, 1'b1, 20);
    chk(8'(seen), 8'(nref));
    // rows closed just before the entry; no termination pin, clock never stopped
    banks = 8'h00;
    ctl.send(drps_pkg::CMD_REF, 1'b0, 30 + $urandom % 100);
    nref++;
    ctl.send(4'($urandom), 1'b0, 4);
    chk({sr, dll}, 8'h02);
    ctl.send(drps_pkg::CMD_NOP, 1'b1, 40);
    chk({sr, dll, rdy, terr}, 8'h06);
    chk(8'(seen), 8'(nref));
    for (int i = 0; i < 4; i++) begin
      banks = i[0] ? 8'h01 << ($urandom % 8) : 8'h00;
      slow = i[1];
      ctl.send(drps_pkg::CMD_NOP, 1'b0, 6);
      chk({pd, apd, dll, boff}, {4'h0, 1'b1, i[0], i[0], 1'b1});
      ctl.send(drps_pkg::CMD_NOP, 1'b1, 14);
      chk({pd, rdy}, 8'h01);
    end
    busy = 1'b1;
    ctl.send(drps_pkg::CMD_NOP, 1'b0, 6);
    chk(pd, 8'h00);
    busy = 1'b0;
    // the loop leaves a row open; the refresh below needs every bank idle
    banks = 8'h00;
    ctl.send(drps_pkg::CMD_NOP, 1'b1, 6);
    ctl.send(drps_pkg::CMD_REF, 1'b1, 2);
    nref++;
    ctl.send(4'h3, 1'b1, 20);
    chk(terr, 8'h01);
    ctl.send(4'h3, 1'b0, 6);
    chk(lost, 8'h01);
    ctl.send(drps_pkg::CMD_NOP, 1'b1, 6);
    dllr = 1'b1;
    @(negedge sys_clk_i);
    dllr = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk({lost, terr}, 8'h00);
    chk(8'(seen), 8'(nref));
    results();
  end
endmodule
`default_nettype wire
